// File: hw/fpe_flash_ctrl.sv
// flash program/erase control registers, mode decode and guards
`timescale 1ns/1ps

module fpe_flash_ctrl
    import fpe_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [7:0]        o_rdata,
    input  wire logic              i_flash_write_enable_pin,
    input  wire logic              i_mode_pin_2,
    input  wire logic              i_mode_pin_1,
    input  wire logic              i_mode_pin_0,
    input  wire logic              i_op_fail,
    input  wire logic              i_sub_active,
    output fpe_array_ctrl_type     o_array,
    output logic                   o_flash_power_down,
    output logic                   o_onboard_programming,
    output fpe_mode_type           o_mode
);

    // elaboration check: fewer than three address bits miss the mode reg
    if (ADDR_W < 3) begin : g_addr_check
        $error("fpe_flash_ctrl: ADDR_W too small for the map");
    end

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // address bits above the map up to bit 7 miss every register; higher bits are dropped
    wire logic [7:0] addr8 = 8'(i_addr);
    wire logic hit_ctrl  = (addr8 == FPE_OFS_CONTROL);
    wire logic hit_stat  = (addr8 == FPE_OFS_STATUS);
    wire logic hit_eblo  = (addr8 == FPE_OFS_EBLK_LO);
    wire logic hit_ebhi  = (addr8 == FPE_OFS_EBLK_HI);
    wire logic hit_emul  = (addr8 == FPE_OFS_EMUL);
    wire logic hit_power = (addr8 == FPE_OFS_POWER);
    wire logic hit_acc   = (addr8 == FPE_OFS_ACCESS);
    wire logic hit_mode  = (addr8 == FPE_OFS_MODE);

    logic [7:0]   ctrl_q,  ctrl_d;
    logic         err_q,   err_d;
    logic [7:0]   eblo_q,  eblo_d;
    logic [1:0]   ebhi_q,  ebhi_d;
    logic [4:0]   emul_q,  emul_d;
    logic         pdd_q,   pdd_d;
    logic [7:0]   acc_q,   acc_d;
    logic [7:0]   rdata_q, rdata_d;
    fpe_mode_type mode_q,  mode_d;
    logic         latched_q;

    wire logic regen    = acc_q[FPE_BIT_REGEN];
    // flash control group is only reachable while mapped
    wire logic fl_grp   = hit_ctrl | hit_stat | hit_eblo | hit_ebhi;
    wire logic wr_gate  = i_wr & (regen | ~fl_grp);
    wire logic flash_write_enable_pin      = i_flash_write_enable_pin;
    wire logic [2:0] md = {i_mode_pin_2, i_mode_pin_1, i_mode_pin_0};

    // ------------------------------------------------------------------
    // mode pin decode, sampled on the cycle after reset release
    // ------------------------------------------------------------------
    // pins must be settled before reset is released; they are taken once
    wire logic md_boot24 = flash_write_enable_pin & (md == FPE_MD_BOOT_24);
    wire logic md_boot16 = flash_write_enable_pin & (md == FPE_MD_BOOT_16);
    wire logic md_user6  = flash_write_enable_pin & (md == FPE_MD_USER_6);
    wire logic md_user7  = flash_write_enable_pin & (md == FPE_MD_USER_7);

    always_comb begin
        mode_d = mode_q;
        if (!latched_q) begin
            if (md_boot24) begin
                mode_d = FPE_MODE_BOOT_24;
            end else if (md_boot16) begin
                mode_d = FPE_MODE_BOOT_16;
            end else if (md_user6) begin
                mode_d = FPE_MODE_USER_6;
            end else if (md_user7) begin
                mode_d = FPE_MODE_USER_7;
            end else begin
                mode_d = FPE_MODE_NORMAL;
            end
        end
    end

    // pins only steer the mode at reset release; later changes ignored
    wire logic onboard = (mode_q != FPE_MODE_NORMAL);

    // ------------------------------------------------------------------
    // first control register: enables, setup and operation bits
    // ------------------------------------------------------------------
    wire logic       ctrl_wr = wr_gate & hit_ctrl;
    wire logic [7:0] ctrl_w  = ctrl_wr ? (i_wdata & FPE_CTRL_WMASK)
                                       : (ctrl_q & FPE_CTRL_WMASK);
    // trade-off: prerequisites are judged on the value being written,
    // so one write may set the enable and a setup bit together
    // write enable also needs a latched on-board mode
    wire logic swe_n   = ctrl_w[FPE_BIT_SWE] & flash_write_enable_pin & onboard;
    wire logic psu_n   = ctrl_w[FPE_BIT_PSETUP] & swe_n;
    wire logic esu_n   = ctrl_w[FPE_BIT_ESETUP] & swe_n;
    // program needs pin, enable and setup; clearing cancels
    wire logic prg_n   = ctrl_w[FPE_BIT_PROGRAM] & psu_n;
    // erase needs enable and erase setup
    wire logic ers_n   = ctrl_w[FPE_BIT_ERASE] & esu_n;

    // pin mirror follows the pin every cycle; software cannot set it
    always_comb begin
        ctrl_d                  = FPE_ZERO_BYTE;
        ctrl_d[FPE_BIT_FWE]     = flash_write_enable_pin;
        ctrl_d[FPE_BIT_SWE]     = swe_n;
        ctrl_d[FPE_BIT_PSETUP]  = psu_n;
        ctrl_d[FPE_BIT_ESETUP]  = esu_n;
        ctrl_d[FPE_BIT_PROGRAM] = prg_n;
        ctrl_d[FPE_BIT_ERASE]   = ers_n;
    end

    // ------------------------------------------------------------------
    // error flag: set by a failed operation, never by software
    // ------------------------------------------------------------------
    wire logic busy = ctrl_q[FPE_BIT_PROGRAM] | ctrl_q[FPE_BIT_ERASE];
    // a failure reported with no operation running is ignored
    assign err_d = err_q | (i_op_fail & busy);

    // ------------------------------------------------------------------
    // erase block selects with one-hot guard
    // ------------------------------------------------------------------
    wire logic [7:0] eblo_w = (wr_gate & hit_eblo)
                            ? (i_wdata & FPE_EBLO_WMASK) : eblo_q;
    // upper six bits of the high select are not stored, read as zero
    wire logic [7:0] ebhi_m = i_wdata & FPE_EBHI_WMASK;
    wire logic [1:0] ebhi_w = (wr_gate & hit_ebhi)
                            ? ebhi_m[1:0] : ebhi_q;
    wire logic [9:0] eb_all = {ebhi_w, eblo_w};
    // judged on the value about to be stored, so a second bit set in
    // either register clears both in the same edge
    // x & (x-1) nonzero means two or more bits set
    wire logic eb_multi = |(eb_all & (eb_all - 10'h001));
    wire logic eb_clear = ~ctrl_d[FPE_BIT_SWE] | eb_multi;
    assign eblo_d = eb_clear ? FPE_ZERO_BYTE : eblo_w;
    assign ebhi_d = eb_clear ? 2'h0 : ebhi_w;

    // ------------------------------------------------------------------
    // emulation, power and access registers (not gated by mapping)
    // ------------------------------------------------------------------
    // these stay writable while the flash group is unmapped
    wire logic [7:0] emul_m = i_wdata & FPE_EMUL_WMASK;
    assign emul_d = (i_wr & hit_emul) ? emul_m[4:0] : emul_q;
    assign pdd_d  = (i_wr & hit_power) ? i_wdata[FPE_BIT_PDDIS] : pdd_q;
    assign acc_d  = (i_wr & hit_acc) ? i_wdata : acc_q;

    wire logic       overlay_on   = emul_q[FPE_BIT_RAMSEL];
    wire logic [2:0] overlay_area = emul_q[2:0];
    // prohibited area codes would hit no 1K block: treat as no overlay
    wire logic area_ok = (overlay_area <= FPE_AREA_MAX);
    // codes above three still protect the array: the safe default
    wire logic protect = err_q | overlay_on;

    // ------------------------------------------------------------------
    // read path, data one cycle after the strobe
    // ------------------------------------------------------------------
    // deselected group reads zero rather than stale contents
    // mode readback: bit 3 on-board, low bits the mode index
    wire logic [7:0] stat_rd = {err_q, 7'h00};
    always_comb begin
        rdata_d = FPE_ZERO_BYTE;
        if (!i_rd) begin
            rdata_d = FPE_ZERO_BYTE;
        end else if (fl_grp && !regen) begin
            rdata_d = FPE_ZERO_BYTE;
        end else if (hit_ctrl) begin
            rdata_d = ctrl_q;
        end else if (hit_stat) begin
            rdata_d = stat_rd;
        end else if (hit_eblo) begin
            rdata_d = eblo_q;
        end else if (hit_ebhi) begin
            rdata_d = {6'h00, ebhi_q};
        end else if (hit_emul) begin
            rdata_d = {3'h0, emul_q};
        end else if (hit_power) begin
            rdata_d = {pdd_q, 7'h00};
        end else if (hit_acc) begin
            rdata_d = acc_q;
        end else if (hit_mode) begin
            rdata_d = {4'h0, onboard, 3'(mode_q)};
        end
    end

    // ------------------------------------------------------------------
    // state: control register and error flag
    // ------------------------------------------------------------------
    // next values come from the named wires above, so each block only
    // chooses between reset and the prepared value
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ctrl_q <= FPE_ZERO_BYTE;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // sticky until reset: software has no way to clear it
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            err_q <= 1'b0;
        end else begin
            err_q <= err_d;
        end
    end

    // ------------------------------------------------------------------
    // state: erase block selects
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            eblo_q <= FPE_ZERO_BYTE;
        end else begin
            eblo_q <= eblo_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ebhi_q <= 2'h0;
        end else begin
            ebhi_q <= ebhi_d;
        end
    end

    // ------------------------------------------------------------------
    // state: emulation, power and access
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            emul_q <= 5'h00;
        end else begin
            emul_q <= emul_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pdd_q <= 1'b0;
        end else begin
            pdd_q <= pdd_d;
        end
    end

    // access register resets unmapped: software must map the group first
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            acc_q <= FPE_ZERO_BYTE;
        end else begin
            acc_q <= acc_d;
        end
    end

    // ------------------------------------------------------------------
    // state: read data and mode latch
    // ------------------------------------------------------------------
    // read data stands one cycle, then falls back to zero
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rdata_q <= FPE_ZERO_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            mode_q <= FPE_MODE_NORMAL;
        end else begin
            mode_q <= mode_d;
        end
    end

    // set at the first edge after release; freezes the mode from then on
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            latched_q <= 1'b0;
        end else begin
            latched_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // outputs to the flash array
    // ------------------------------------------------------------------
    assign o_rdata = rdata_q;
    assign o_array.program_active = ctrl_q[FPE_BIT_PROGRAM] & ~protect;
    assign o_array.erase_active   = ctrl_q[FPE_BIT_ERASE] & ~protect;
    assign o_array.program_setup  = ctrl_q[FPE_BIT_PSETUP];
    assign o_array.erase_setup    = ctrl_q[FPE_BIT_ESETUP];
    assign o_array.erase_blocks   = {ebhi_q, eblo_q};
    assign o_array.overlay_on     = overlay_on & area_ok;
    assign o_array.overlay_area   = overlay_area;
    assign o_array.power_down_disable = pdd_q;
    assign o_array.error_protect  = err_q;

    // ------------------------------------------------------------------
    // outputs: power and mode
    // ------------------------------------------------------------------
    // limitation: power-down follows sub-active with no settling delay
    assign o_flash_power_down     = i_sub_active & ~pdd_q;
    assign o_onboard_programming  = onboard;
    assign o_mode                 = mode_q;

endmodule // fpe_flash_ctrl

// File: hw/fpe_pkg.sv
// package: register map, fields and types for flash program/erase control
package fpe_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [7:0] FPE_OFS_CONTROL  = 8'h00;
    localparam logic [7:0] FPE_OFS_STATUS   = 8'h01;
    localparam logic [7:0] FPE_OFS_EBLK_LO  = 8'h02;
    localparam logic [7:0] FPE_OFS_EBLK_HI  = 8'h03;
    localparam logic [7:0] FPE_OFS_EMUL     = 8'h04;
    localparam logic [7:0] FPE_OFS_POWER    = 8'h05;
    localparam logic [7:0] FPE_OFS_ACCESS   = 8'h06;
    localparam logic [7:0] FPE_OFS_MODE     = 8'h07;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int FPE_BIT_PROGRAM   = 0;
    localparam int FPE_BIT_ERASE     = 1;
    localparam int FPE_BIT_PSETUP    = 4;
    localparam int FPE_BIT_ESETUP    = 5;
    localparam int FPE_BIT_SWE       = 6;
    localparam int FPE_BIT_FWE       = 7;
    localparam int FPE_BIT_ERROR     = 7;
    localparam int FPE_BIT_RAMSEL    = 3;
    localparam int FPE_BIT_PDDIS     = 7;
    localparam int FPE_BIT_REGEN     = 3;

    localparam logic [7:0] FPE_ZERO_BYTE   = 8'h00;
    localparam logic [7:0] FPE_CTRL_WMASK  = 8'h73;
    localparam logic [7:0] FPE_EBLO_WMASK  = 8'hff;
    localparam logic [7:0] FPE_EBHI_WMASK  = 8'h03;
    localparam logic [7:0] FPE_EMUL_WMASK  = 8'h1f;
    localparam logic [2:0] FPE_AREA_MAX    = 3'h3;

    // mode pin codes, write-enable pin high
    localparam logic [2:0] FPE_MD_BOOT_24  = 3'h2;
    localparam logic [2:0] FPE_MD_BOOT_16  = 3'h3;
    localparam logic [2:0] FPE_MD_USER_6   = 3'h6;
    localparam logic [2:0] FPE_MD_USER_7   = 3'h7;

    typedef enum logic [2:0] {
        FPE_MODE_NORMAL,
        FPE_MODE_BOOT_24,
        FPE_MODE_BOOT_16,
        FPE_MODE_USER_6,
        FPE_MODE_USER_7
    } fpe_mode_type;

    typedef struct packed {
        logic       program_active;
        logic       erase_active;
        logic       program_setup;
        logic       erase_setup;
        logic [9:0] erase_blocks;
        logic       overlay_on;
        logic [2:0] overlay_area;
        logic       power_down_disable;
        logic       error_protect;
    } fpe_array_ctrl_type;

endpackage

// File: test/flash_program_erase_control_tb.sv
// testbench: register scenarios for flash program/erase control
`timescale 1ns/1ps
module flash_program_erase_control_tb;
    import fpe_pkg::*;
    logic               i_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0;
    logic               pin = 1, fail = 0, sub = 0, pd, onb;
    logic [2:0]         md = 3'h7;
    logic [7:0]         i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    fpe_array_ctrl_type a;
    fpe_mode_type       mode;
    int                 error_cnt = 0, checked = 0;

    always #20 i_clk = ~i_clk;

    fpe_flash_ctrl #(.ADDR_W(8)) uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_flash_write_enable_pin(pin), .i_mode_pin_2(md[2]),
        .i_mode_pin_1(md[1]), .i_mode_pin_0(md[0]), .i_op_fail(fail),
        .i_sub_active(sub), .o_array(a), .o_flash_power_down(pd),
        .o_onboard_programming(onb), .o_mode(mode));

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // bus cycles; mode pins are latched one edge after release
    // ------------------------------------------------------------------
    task automatic rst;
        @(posedge i_clk) i_reset_n <= 0;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= ad;
        i_wdata <= d;
        i_wr <= 1;
        @(posedge i_clk);
        i_wr <= 0;
        #1;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= ad;
        i_rd <= 1;
        @(posedge i_clk);
        i_rd <= 0;
        #1 chk(20'(o_rdata), 20'(e));
    endtask
    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_modes;
        logic [3:0] code [6] = '{4'h9, 4'h7, 4'hA, 4'hB, 4'hE, 4'hF};
        fpe_mode_type exp [6] = '{FPE_MODE_NORMAL, FPE_MODE_NORMAL,
            FPE_MODE_BOOT_24, FPE_MODE_BOOT_16, FPE_MODE_USER_6,
            FPE_MODE_USER_7};
        for (int k = 0; k < 6; k++) begin
            @(posedge i_clk) {pin, md} <= code[k];
            rst();
            chk(20'(mode), 20'(exp[k]));
            chk(20'(onb), 20'(k > 1));
        end
        rd(FPE_OFS_MODE, 8'h0C);
    endtask
    task automatic t_access;
        wr(FPE_OFS_CONTROL, 8'h40);
        rd(FPE_OFS_CONTROL, 8'h00);
        wr(FPE_OFS_ACCESS, 8'h08);
        rd(FPE_OFS_ACCESS, 8'h08);
        rd(FPE_OFS_CONTROL, 8'h80);
        wr(FPE_OFS_CONTROL, 8'h40);
        wr(FPE_OFS_ACCESS, 8'h00);
        wr(FPE_OFS_ACCESS, 8'h08);
        rd(FPE_OFS_CONTROL, 8'hC0);
    endtask
    task automatic t_program;
        wr(FPE_OFS_CONTROL, 8'h41);
        rd(FPE_OFS_CONTROL, 8'hC0);
        wr(FPE_OFS_CONTROL, 8'h50);
        wr(FPE_OFS_CONTROL, 8'h51);
        chk(20'(a.program_active), 20'h1);
        rd(FPE_OFS_CONTROL, 8'hD1);
        wr(FPE_OFS_CONTROL, 8'h50);
        chk(20'(a.program_active), 20'h0);
        wr(FPE_OFS_CONTROL, 8'h51);
        @(posedge i_clk) pin <= 0;
        tick();
        chk(20'(a.program_active), 20'h0);
        rd(FPE_OFS_CONTROL, 8'h00);
        @(posedge i_clk) pin <= 1;
    endtask
    task automatic t_erase;
        wr(FPE_OFS_CONTROL, 8'h40);
        wr(FPE_OFS_CONTROL, 8'h42);
        rd(FPE_OFS_CONTROL, 8'hC0);
        wr(FPE_OFS_CONTROL, 8'h60);
        wr(FPE_OFS_CONTROL, 8'h62);
        chk(20'(a.erase_active), 20'h1);
        wr(FPE_OFS_CONTROL, 8'h60);
        chk(20'(a.erase_active), 20'h0);
    endtask
    task automatic t_blocks;
        wr(FPE_OFS_EBLK_LO, 8'h80);
        chk(20'(a.erase_blocks), 20'h00080);
        wr(FPE_OFS_EBLK_HI, 8'h01);
        rd(FPE_OFS_EBLK_LO, 8'h00);
        rd(FPE_OFS_EBLK_HI, 8'h00);
        wr(FPE_OFS_EBLK_HI, 8'hFE);
        rd(FPE_OFS_EBLK_HI, 8'h02);
        chk(20'(a.erase_blocks), 20'h00200);
        wr(FPE_OFS_CONTROL, 8'h00);
        chk(20'(a.erase_blocks), 20'h00000);
        wr(FPE_OFS_EBLK_LO, 8'h01);
        rd(FPE_OFS_EBLK_LO, 8'h00);
    endtask
    // overlay must gate an active program bit and release it again
    task automatic t_overlay;
        wr(FPE_OFS_CONTROL, 8'h40);
        wr(FPE_OFS_CONTROL, 8'h50);
        wr(FPE_OFS_CONTROL, 8'h51);
        wr(FPE_OFS_EMUL, 8'h0A);
        chk({a.overlay_on, a.overlay_area, a.program_active}, 20'h14);
        rd(FPE_OFS_EMUL, 8'h0A);
        wr(FPE_OFS_EMUL, 8'h0C);
        chk({a.overlay_on, a.overlay_area, a.program_active}, 20'h08);
        wr(FPE_OFS_EMUL, 8'hFF);
        rd(FPE_OFS_EMUL, 8'h1F);
        wr(FPE_OFS_EMUL, 8'h00);
        chk(20'(a.program_active), 20'h1);
    endtask
    task automatic t_power;
        @(posedge i_clk) sub <= 1;
        tick();
        chk(20'(pd), 20'h1);
        wr(FPE_OFS_POWER, 8'hFF);
        chk(20'(pd), 20'h0);
        chk(20'(a.power_down_disable), 20'h1);
        rd(FPE_OFS_POWER, 8'h80);
        rd(8'h20, 8'h00);
    endtask
    task automatic t_status;
        @(posedge i_clk) fail <= 1;
        @(posedge i_clk) fail <= 0;
        #1 chk({a.error_protect, a.program_active}, 20'h2);
        rd(FPE_OFS_STATUS, 8'h80);
        wr(FPE_OFS_STATUS, 8'h7F);
        rd(FPE_OFS_STATUS, 8'h80);
    endtask

    initial begin
        t_modes();
        t_access();
        t_program();
        t_erase();
        t_blocks();
        t_overlay();
        t_power();
        t_status();
        report_and_stop();
    end
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
endmodule // flash_program_erase_control_tb

// File: test/fpe_flash_ctrl_props.sv
// checker: port properties of the flash program/erase control block
`timescale 1ns/1ps
module fpe_flash_ctrl_props
    import fpe_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic               i_clk,
    input wire logic               i_reset_n,
    input wire logic [ADDR_W-1:0]  i_addr,
    input wire logic [7:0]         i_wdata,
    input wire logic               i_wr,
    input wire logic               i_rd,
    input wire logic [7:0]         o_rdata,
    input wire logic               i_flash_write_enable_pin,
    input wire logic               i_mode_pin_2,
    input wire logic               i_mode_pin_1,
    input wire logic               i_mode_pin_0,
    input wire logic               i_op_fail,
    input wire logic               i_sub_active,
    input wire fpe_array_ctrl_type o_array,
    input wire logic               o_flash_power_down,
    input wire logic               o_onboard_programming,
    input wire fpe_mode_type       o_mode
);
    fpe_array_ctrl_type a;
    assign a = o_array;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // ------------------------------------------------------------------
    // gating and protection
    // ------------------------------------------------------------------
    prog_gate_a: assert property (
        a.program_active |-> a.program_setup && $past(i_flash_write_enable_pin))
        else $error("program active without setup or pin");
    erase_gate_a: assert property (
        a.erase_active |-> a.erase_setup)
        else $error("erase active without erase setup");
    error_set_a: assert property (
        i_op_fail && (a.program_active || a.erase_active) |=> a.error_protect)
        else $error("failure did not raise error flag");
    error_hold_a: assert property (
        a.error_protect |=> a.error_protect)
        else $error("error flag dropped before reset");
    protect_on_a: assert property (
        a.error_protect || a.overlay_on |-> !a.program_active && !a.erase_active)
        else $error("program or erase while protected");
    // ------------------------------------------------------------------
    // registers and decode
    // ------------------------------------------------------------------
    status_rsv_a: assert property (
        $past(i_rd) && $past(i_addr) == ADDR_W'(FPE_OFS_STATUS)
        |-> o_rdata[6:0] == 7'h00)
        else $error("status reserved bits not zero");
    one_block_a: assert property (
        $onehot0(a.erase_blocks))
        else $error("several erase blocks selected");
    pin_clear_a: assert property (
        !i_flash_write_enable_pin |=> a.erase_blocks == 10'h000
        && !a.program_setup && !a.erase_setup)
        else $error("selects kept after write enable pin low");
    area_ok_a: assert property (
        a.overlay_on |-> a.overlay_area <= FPE_AREA_MAX)
        else $error("overlay on with prohibited area");
    power_down_a: assert property (
        o_flash_power_down == (i_sub_active && !a.power_down_disable))
        else $error("power-down output wrong");
    mode_hold_a: assert property (
        $past(i_reset_n) && $past(i_reset_n, 2) |-> $stable(o_mode))
        else $error("mode changed outside reset");
endmodule // fpe_flash_ctrl_props

bind fpe_flash_ctrl fpe_flash_ctrl_props #(.ADDR_W(ADDR_W)) u_props (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_flash_write_enable_pin(i_flash_write_enable_pin),
    .i_mode_pin_2(i_mode_pin_2), .i_mode_pin_1(i_mode_pin_1),
    .i_mode_pin_0(i_mode_pin_0), .i_op_fail(i_op_fail),
    .i_sub_active(i_sub_active), .o_array(o_array),
    .o_flash_power_down(o_flash_power_down),
    .o_onboard_programming(o_onboard_programming), .o_mode(o_mode));
